// >>> dv/pamp_port_regs_bench.sv
// self-checking bench for the per-port list, mirroring and priority register bank
`timescale 1ns/1ps
module pamp_port_regs_bench
  import pamp_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic                                     clk_sys_i;
  logic                                     rst_i;
  logic [ADDR_W-1:0]                        paddr_i;
  logic                                     psel_i;
  logic                                     penable_i;
  logic                                     pwrite_i;
  logic [31:0]                              pwdata_i;
  logic [3:0]                               pstrb_i;
  logic [31:0]                              prdata_o;
  logic                                     pready_o;
  logic                                     pslverr_o;
  logic [NUM_PORTS-1:0]                     acl_start_i;
  logic [NUM_PORTS-1:0][ENTRY_BYTES-1:0]    acl_byte_en_i;
  logic [NUM_PORTS-1:0][8*ENTRY_BYTES-1:0]  acl_wdata_i;
  logic [NUM_PORTS-1:0][8*ENTRY_BYTES-1:0]  acl_rdata_o;
  logic [NUM_PORTS-1:0]                     rx_pkt_i;
  logic [NUM_PORTS-1:0]                     tx_pkt_i;
  logic [NUM_PORTS-1:0]                     rx_monitor_o;
  logic [NUM_PORTS-1:0]                     tx_monitor_o;
  logic [NUM_PORTS-1:0]                     sniffer_port_o;
  logic [NUM_PORTS-1:0]                     ing_pkt_i;
  logic [NUM_PORTS-1:0][NUM_SRC-1:0]        src_valid_i;
  logic [NUM_PORTS-1:0][NUM_SRC-1:0][2:0]   src_prio_i;
  logic [NUM_PORTS-1:0][2:0]                default_prio_i;
  logic [NUM_PORTS-1:0][NUM_SRC-1:0]        class_en_o;
  logic [NUM_PORTS-1:0]                     ing_prio_vld_o;
  logic [NUM_PORTS-1:0][2:0]                ing_prio_o;
  int                                       n_fail;    // mismatches seen
  int                                       n_checks;  // comparisons made

  pamp_port_regs dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .acl_start_i(acl_start_i), .acl_byte_en_i(acl_byte_en_i), .acl_wdata_i(acl_wdata_i),
    .acl_rdata_o(acl_rdata_o), .rx_pkt_i(rx_pkt_i), .tx_pkt_i(tx_pkt_i),
    .rx_monitor_o(rx_monitor_o), .tx_monitor_o(tx_monitor_o),
    .sniffer_port_o(sniffer_port_o), .ing_pkt_i(ing_pkt_i), .src_valid_i(src_valid_i),
    .src_prio_i(src_prio_i), .default_prio_i(default_prio_i), .class_en_o(class_en_o),
    .ing_prio_vld_o(ing_prio_vld_o), .ing_prio_o(ing_prio_o)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // 25 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // byte address of a register in a port group
  function automatic logic [ADDR_W-1:0] ad(input int p, input logic [11:0] idx);
    return {p[1:0], idx, 2'b00};
  endfunction : ad

  // one comparison, wide enough for a table entry
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; waits for pready, only the watchdog ends a hung wait
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge clk_sys_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    paddr_i   <= a;
    pwrite_i  <= wr;
    pwdata_i  <= {24'h00_0000, d};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  // read a register and compare data and error flag
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic ee);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 8'h00, rd, er);
    chk({96'h0, rd}, {120'h0, e});
    chk({127'h0, er}, {127'h0, ee});
  endtask : rdc

  // table operation: program direction and index, pulse start, poll its done flag
  task automatic tab(input int p, input logic dir, input logic [3:0] idx,
                     input logic [15:0] be);
    logic [31:0] rd;
    logic        er;
    int          n;
    int          b;
    b = dir ? ACL_WR_DONE_BIT : ACL_RD_DONE_BIT;
    apb(1'b1, ad(p, ACL_CTRL_IDX), {3'h0, dir, idx}, rd, er);
    @(posedge clk_sys_i);
    acl_start_i[p-1]   <= 1'b1;
    acl_byte_en_i[p-1] <= be;
    @(posedge clk_sys_i);
    acl_start_i[p-1]   <= 1'b0;
    apb(1'b0, ad(p, ACL_CTRL_IDX), 8'h00, rd, er);
    chk({127'h0, rd[b]}, 128'h0);
    n = 0;
    do begin
      apb(1'b0, ad(p, ACL_CTRL_IDX), 8'h00, rd, er);
      n++;
    end while (rd[b] !== 1'b1 && n < 8);
    chk({127'h0, rd[b]}, 128'h1);
  endtask : tab

  // verdict and end of run
  task automatic test_done();
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // watchdog: the tests need well under a thousand cycles
  initial begin
    #(40 * 5000);
    n_fail++;
    test_done();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0]  rd;
    logic         er;
    logic [127:0] ea;
    logic [7:0]   pv [4];
    logic [2:0]   pe [4];
    pv = '{8'h8B, 8'h43, 8'h0C, 8'h80};
    pe = '{3'd5, 3'd7, 3'd1, 3'd6};
    n_fail = 0;
    n_checks = 0;
    rst_i = 1'b1;
    {paddr_i, psel_i, penable_i, pwrite_i, pwdata_i} = '0;
    pstrb_i = 4'h1;
    {acl_start_i, acl_byte_en_i, acl_wdata_i, rx_pkt_i, tx_pkt_i, ing_pkt_i} = '0;
    src_valid_i = '1;
    src_prio_i = '0;
    src_prio_i[1] = {3'd4, 3'd3, 3'd1, 3'd5, 3'd2};  // station, vlan, user, diffserv, list
    default_prio_i = {3'd2, 3'd6, 3'd1};
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // reset values of every port group
    for (int p = 1; p <= 3; p++) begin
      rdc(ad(p, ACL_CTRL_IDX), 8'h60, 1'b0);
      rdc(ad(p, MIRROR_IDX), 8'h00, 1'b0);
      rdc(ad(p, PRIO_IDX), 8'h00, 1'b0);
    end
    // unmapped places answer with an error and read zero
    rdc(16'h0000, 8'h00, 1'b1);
    apb(1'b1, ad(1, 12'h802), 8'hFF, rd, er);
    chk({127'h0, er}, 128'h1);
    // a write without the low byte strobe is ignored
    pstrb_i <= 4'h0;
    apb(1'b1, ad(1, MIRROR_IDX), 8'hFF, rd, er);
    pstrb_i <= 4'h1;
    rdc(ad(1, MIRROR_IDX), 8'h00, 1'b0);
    // all ones: reserved bits stay zero, done flags stay set
    for (int p = 1; p <= 3; p++) begin
      apb(1'b1, ad(p, ACL_CTRL_IDX), 8'hFF, rd, er);
      apb(1'b1, ad(p, MIRROR_IDX), 8'hFF, rd, er);
      apb(1'b1, ad(p, PRIO_IDX), 8'hFF, rd, er);
      rdc(ad(p, ACL_CTRL_IDX), 8'h7F, 1'b0);
      rdc(ad(p, MIRROR_IDX), 8'h62, 1'b0);
      rdc(ad(p, PRIO_IDX), 8'hDF, 1'b0);
    end
    chk({125'h0, sniffer_port_o}, 128'h7);
    chk({113'h0, class_en_o}, {113'h0, {3{5'h1F}}});
    // mirroring: each port gets a different control
    apb(1'b1, ad(1, MIRROR_IDX), 8'h40, rd, er);
    apb(1'b1, ad(2, MIRROR_IDX), 8'h20, rd, er);
    apb(1'b1, ad(3, MIRROR_IDX), 8'h02, rd, er); // global control lives outside
    @(posedge clk_sys_i);
    rx_pkt_i <= 3'b111;
    tx_pkt_i <= 3'b111;
    @(posedge clk_sys_i);
    rx_pkt_i <= 3'b000;
    tx_pkt_i <= 3'b000;
    #1;
    chk({122'h0, rx_monitor_o, tx_monitor_o}, {122'h0, 3'b001, 3'b010});
    chk({125'h0, sniffer_port_o}, 128'h4);
    @(posedge clk_sys_i);
    #1;
    chk({122'h0, rx_monitor_o, tx_monitor_o}, 128'h0);
    // table: full write, partial overwrite, then reads on port 3
    ea = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;
    acl_wdata_i[2] <= ea;
    tab(3, 1'b1, 4'h3, 16'hFFFF);
    acl_wdata_i[2] <= 128'h1234_5678_9ABC_DEF0_0FED_CBA9_8765_4321;
    tab(3, 1'b1, 4'h3, 16'h00FF);
    acl_wdata_i[2] <= 128'h5A5A_5A5A_C3C3_C3C3_F00F_F00F_1357_9BDF;
    tab(3, 1'b1, 4'h5, 16'hFFFF);
    tab(3, 1'b0, 4'h3, 16'hFFFF);
    chk(acl_rdata_o[2], {ea[127:64], 64'h0FED_CBA9_8765_4321});
    tab(3, 1'b0, 4'h5, 16'h000F);
    chk(acl_rdata_o[2], {ea[127:64], 32'h0FED_CBA9, 32'h1357_9BDF});
    // port 1 table: write then read back one entry
    acl_wdata_i[0] <= ea;
    tab(1, 1'b1, 4'hA, 16'hFFFF);
    tab(1, 1'b0, 4'hA, 16'hFFFF);
    chk(acl_rdata_o[0], ea);
    // priority combining modes on port 2
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ad(2, PRIO_IDX), pv[i], rd, er);
      @(posedge clk_sys_i);
      ing_pkt_i[1] <= 1'b1;
      @(posedge clk_sys_i);
      ing_pkt_i[1] <= 1'b0;
      #1;
      chk({124'h0, ing_prio_vld_o[1], ing_prio_o[1]}, {124'h0, 1'b1, pe[i]});
      chk({123'h0, class_en_o[1]}, {123'h0, pv[i][4:0]});
    end
    // advised use: a single bit set, diffserv only
    apb(1'b1, ad(2, PRIO_IDX), 8'h02, rd, er);
    @(posedge clk_sys_i);
    ing_pkt_i[1] <= 1'b1;
    @(posedge clk_sys_i);
    ing_pkt_i[1] <= 1'b0;
    #1;
    chk({124'h0, ing_prio_vld_o[1], ing_prio_o[1]}, {124'h0, 1'b1, 3'd5});
    test_done();
  end

endmodule : pamp_port_regs_bench

// >>> rtl/pamp_port_regs.sv
// per-port list table access, mirroring and ingress priority register bank
//
// Summary of operation
// - one 8-bit register group per port 1-3
// - write done bit 6 low until write ends
// - read done bit 5 low until read ends
// - table access starts on byte-enable low write; here it starts on an acl_start_i pulse
// - only enabled access bytes are transferred
// - receive sniff marks received packets monitored
// - transmit sniff marks transmitted packets monitored
// - sniffer bit makes port the mirror destination
// - highest mode takes largest enabled source priority
// - or mode ors all enabled source priorities
// - bit 4 enables station address classification
// - bit 3 enables virtual lan classification
// - bit 2 enables user priority tag classification
// - bit 1 enables diffserv classification
// - bit 0 enables list rule classification
// - no source gives priority: use default
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module pamp_port_regs
  import pamp_pkg::*;
(
  // clock and reset
  input  wire logic                               clk_sys_i,
  input  wire logic                               rst_i,
  // apb slave
  input  wire logic [ADDR_W-1:0]                  paddr_i,
  input  wire logic                               psel_i,
  input  wire logic                               penable_i,
  input  wire logic                               pwrite_i,
  input  wire logic [31:0]                        pwdata_i,
  input  wire logic [3:0]                         pstrb_i,
  output logic      [31:0]                        prdata_o,
  output logic                                    pready_o,
  output logic                                    pslverr_o,
  // list table access data, held outside this block
  input  wire logic [NUM_PORTS-1:0]               acl_start_i,
  input  wire logic [NUM_PORTS-1:0][ENTRY_BYTES-1:0] acl_byte_en_i,
  input  wire logic [NUM_PORTS-1:0][8*ENTRY_BYTES-1:0] acl_wdata_i,
  output logic      [NUM_PORTS-1:0][8*ENTRY_BYTES-1:0] acl_rdata_o,
  // mirroring
  input  wire logic [NUM_PORTS-1:0]               rx_pkt_i,
  input  wire logic [NUM_PORTS-1:0]               tx_pkt_i,
  output logic      [NUM_PORTS-1:0]               rx_monitor_o,
  output logic      [NUM_PORTS-1:0]               tx_monitor_o,
  output logic      [NUM_PORTS-1:0]               sniffer_port_o,
  // ingress priority classification
  input  wire logic [NUM_PORTS-1:0]               ing_pkt_i,
  input  wire logic [NUM_PORTS-1:0][NUM_SRC-1:0]  src_valid_i,
  input  wire logic [NUM_PORTS-1:0][NUM_SRC-1:0][2:0] src_prio_i,
  input  wire logic [NUM_PORTS-1:0][2:0]          default_prio_i,
  output logic      [NUM_PORTS-1:0][NUM_SRC-1:0]  class_en_o,
  output logic      [NUM_PORTS-1:0]               ing_prio_vld_o,
  output logic      [NUM_PORTS-1:0][2:0]          ing_prio_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PORTS-1:0][3:0]             idx;       // selected table entry
    logic [NUM_PORTS-1:0]                  dir;       // 1 write, 0 read
    logic [NUM_PORTS-1:0]                  wr_done;   // write complete flag
    logic [NUM_PORTS-1:0]                  rd_done;   // read complete flag
    logic [NUM_PORTS-1:0]                  busy;      // table op in flight
    logic [NUM_PORTS-1:0][1:0]             cnt;       // op cycles left
    logic [NUM_PORTS-1:0]                  op_dir;    // direction latched at start
    logic [NUM_PORTS-1:0][3:0]             op_idx;    // entry latched at start
    logic [NUM_PORTS-1:0][ENTRY_BYTES-1:0] op_be;     // byte enables latched
    logic [NUM_PORTS-1:0][8*ENTRY_BYTES-1:0] rd_data; // read result bytes
    logic [NUM_PORTS-1:0]                  rx_sniff;
    logic [NUM_PORTS-1:0]                  tx_sniff;
    logic [NUM_PORTS-1:0]                  sniffer;
    logic [NUM_PORTS-1:0][7:0]             prio_ctl;  // reserved bit kept zero
    logic [NUM_PORTS-1:0]                  rx_mon;
    logic [NUM_PORTS-1:0]                  tx_mon;
    logic [NUM_PORTS-1:0]                  prio_vld;
    logic [NUM_PORTS-1:0][2:0]             prio;
    logic [31:0]                           prdata;
    logic                                  pready;
    logic                                  pslverr;
  } pamp_state_s;

  pamp_state_s state_q;                               // registered state
  pamp_state_s state_d;                               // next state
  logic [8*ENTRY_BYTES-1:0] table_q [NUM_PORTS][ENTRIES]; // list table storage

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // address decode: sel 0 none, 1 list control, 2 mirroring, 3 priority
  function automatic logic [3:0] pamp_decode(input logic [ADDR_W-1:0] a);
    logic [1:0] port;
    logic [1:0] sel;
    port = a[ADDR_W-1 -: 2];
    sel  = 2'd0;
    if (a[1:0] == 2'b00 && port != 2'd0) begin
      if (a[13:2] == ACL_CTRL_IDX) sel = 2'd1;
      else if (a[13:2] == MIRROR_IDX) sel = 2'd2;
      else if (a[13:2] == PRIO_IDX) sel = 2'd3;
    end
    return {port - 2'd1, sel};                         // zero-based port, select
  endfunction : pamp_decode

  // resolve the ingress priority from the enabled sources
  function automatic logic [3:0] pamp_resolve(input logic [7:0] ctl,
                                              input logic [NUM_SRC-1:0] vld,
                                              input logic [NUM_SRC-1:0][2:0] val,
                                              input logic [2:0] dflt);
    logic [NUM_SRC-1:0] use_src;
    logic [2:0]         hi;
    logic [2:0]         orv;
    logic [2:0]         first;
    logic               found;
    use_src = vld & ctl[PRI_EN_LSB +: NUM_SRC];
    hi      = 3'd0;
    orv     = 3'd0;
    first   = 3'd0;
    found   = 1'b0;
    for (int s = NUM_SRC - 1; s >= 0; s--) begin
      if (use_src[s]) begin
        if (val[s] > hi) hi = val[s];
        orv   = orv | val[s];
        first = val[s];                               // lowest bit source wins
        found = 1'b1;
      end
    end
    if (!found) return {1'b1, dflt};
    if (ctl[PRI_HIGHEST_BIT]) return {1'b1, hi};
    if (ctl[PRI_OR_BIT]) return {1'b1, orv};
    return {1'b1, first};
  endfunction : pamp_resolve

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [3:0] dec;       // decode of current address
  logic [1:0] dport;     // zero-based port of current address
  logic       wr_fire;   // write takes effect at this edge
  logic [3:0] res;       // priority resolver result, valid and value

  always_comb begin
    state_d = state_q;
    dec     = pamp_decode(paddr_i);
    dport   = dec[3:2];
    res     = 4'd0;
    wr_fire = psel_i && penable_i && state_q.pready && pwrite_i && pstrb_i[0];
    // apb: no wait state; read data is registered in the setup cycle, so it comes from a flop
    state_d.pready  = psel_i && !penable_i && !state_q.pready;
    state_d.pslverr = psel_i && !penable_i && !state_q.pready && dec[1:0] == 2'd0;
    state_d.prdata  = 32'h0000_0000;
    if (psel_i && !penable_i && !pwrite_i) begin
      case (dec[1:0])
        2'd1: state_d.prdata[7:0] = {1'b0, state_q.wr_done[dport],
                                     state_q.rd_done[dport], state_q.dir[dport],
                                     state_q.idx[dport]};
        2'd2: state_d.prdata[7:0] = {1'b0, state_q.rx_sniff[dport],
                                     state_q.tx_sniff[dport], 3'b000,
                                     state_q.sniffer[dport], 1'b0};
        2'd3: state_d.prdata[7:0] = state_q.prio_ctl[dport];
        default: state_d.prdata = 32'h0000_0000;
      endcase
    end
    // register writes, reserved bits dropped
    if (wr_fire) begin
      case (dec[1:0])
        2'd1: begin
          state_d.dir[dport] = pwdata_i[ACL_DIR_BIT];
          state_d.idx[dport] = pwdata_i[ACL_IDX_LSB +: 4];
        end
        2'd2: begin
          state_d.rx_sniff[dport] = pwdata_i[MIR_RX_BIT];
          state_d.tx_sniff[dport] = pwdata_i[MIR_TX_BIT];
          state_d.sniffer[dport]  = pwdata_i[MIR_SNIFFER_BIT];
        end
        2'd3: state_d.prio_ctl[dport] = pwdata_i[7:0] & 8'b1101_1111;
        default: ;                                    // unmapped write: no effect, error already given
      endcase
    end
    // per port: table engine, mirroring marks, priority
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (state_q.busy[p]) begin
        if (state_q.cnt[p] == 2'd0) begin
          state_d.busy[p] = 1'b0;
          if (state_q.op_dir[p]) state_d.wr_done[p] = 1'b1;
          else state_d.rd_done[p] = 1'b1;
          if (!state_q.op_dir[p]) begin
            for (int b = 0; b < ENTRY_BYTES; b++) begin
              if (state_q.op_be[p][b])
                state_d.rd_data[p][8*b +: 8] = table_q[p][state_q.op_idx[p]][8*b +: 8];
            end
          end
        end else begin
          state_d.cnt[p] = state_q.cnt[p] - 2'd1;
        end
      end else if (acl_start_i[p]) begin
        // a start while busy is ignored; the op in flight keeps its setup
        state_d.busy[p]   = 1'b1;
        state_d.cnt[p]    = ACL_OP_CYCLES_M1;
        state_d.op_dir[p] = state_q.dir[p];
        state_d.op_idx[p] = state_q.idx[p];
        state_d.op_be[p]  = acl_byte_en_i[p];
        if (state_q.dir[p]) state_d.wr_done[p] = 1'b0;
        else state_d.rd_done[p] = 1'b0;
      end
      state_d.rx_mon[p] = rx_pkt_i[p] && state_q.rx_sniff[p];
      state_d.tx_mon[p] = tx_pkt_i[p] && state_q.tx_sniff[p];
      res = pamp_resolve(state_q.prio_ctl[p], src_valid_i[p], src_prio_i[p],
                         default_prio_i[p]);
      state_d.prio_vld[p] = ing_pkt_i[p];
      if (ing_pkt_i[p]) state_d.prio[p] = res[2:0];
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q         <= '0;
      state_q.wr_done <= {NUM_PORTS{DONE_RST}};
      state_q.rd_done <= {NUM_PORTS{DONE_RST}};
    end else begin
      state_q <= state_d;
    end
  end

  // table storage: no reset, written when a write op completes
  always_ff @(posedge clk_sys_i) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (state_q.busy[p] && state_q.cnt[p] == 2'd0 && state_q.op_dir[p]) begin
        for (int b = 0; b < ENTRY_BYTES; b++) begin
          if (state_q.op_be[p][b])
            table_q[p][state_q.op_idx[p]][8*b +: 8] <= acl_wdata_i[p][8*b +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign prdata_o       = state_q.prdata;
  assign pready_o       = state_q.pready;
  assign pslverr_o      = state_q.pslverr;
  assign acl_rdata_o    = state_q.rd_data;
  assign rx_monitor_o   = state_q.rx_mon;
  assign tx_monitor_o   = state_q.tx_mon;
  assign sniffer_port_o = state_q.sniffer;
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      class_en_o[p] = state_q.prio_ctl[p][PRI_EN_LSB +: NUM_SRC];
    end
  end
  assign ing_prio_vld_o = state_q.prio_vld;
  assign ing_prio_o     = state_q.prio;

  // ----------------------------------------------------------------
  // assertions (port 1 group; priority checks on port 2, where the bench drives packets)
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence rd_start_s;
    acl_start_i[0] && !state_q.busy[0] && !state_q.dir[0];
  endsequence
  sequence rd_wait_s;
    ##1 !state_q.rd_done[0] [*4] ##1 state_q.rd_done[0];
  endsequence

  apb_setup_ready_a: assert property (psel_i && !penable_i && !pready_o |=> pready_o)
    else $error("apb answer missing after setup");
  read_done_wait_a: assert property (rd_start_s |-> rd_wait_s)
    else $error("read done flag timing wrong");
  write_done_clr_a: assert property (
    acl_start_i[0] && !state_q.busy[0] && state_q.dir[0]
    |=> !state_q.wr_done[0] [*4] ##1 state_q.wr_done[0])
    else $error("write done flag timing wrong");
  ctrl_idx_write_a: assert property (
    wr_fire && dec == 4'b0001 |=> state_q.idx[0] == $past(pwdata_i[3:0]))
    else $error("entry index not stored");
  rx_sniff_mark_a: assert property (
    rx_pkt_i[0] && state_q.rx_sniff[0] |=> rx_monitor_o[0])
    else $error("received packet not marked");
  tx_sniff_mark_a: assert property (
    tx_pkt_i[0] |=> tx_monitor_o[0] == $past(state_q.tx_sniff[0]))
    else $error("transmitted packet mark wrong");
  default_prio_use_a: assert property (
    ing_pkt_i[1] && (src_valid_i[1] & state_q.prio_ctl[1][4:0]) == 5'd0
    |=> ing_prio_o[1] == $past(default_prio_i[1]))
    else $error("default priority not used");
  mirror_rsvd_zero_a: assert property (
    psel_i && !penable_i && !pwrite_i && dec == 4'b0010
    |=> prdata_o[7] == 1'b0 && prdata_o[4:2] == 3'b000 && prdata_o[0] == 1'b0)
    else $error("reserved mirroring bits not zero");
  or_mode_prio_a: assert property (
    ing_pkt_i[1] && state_q.prio_ctl[1] == 8'h43 && src_valid_i[1][1:0] == 2'b11
    |=> ing_prio_o[1] == ($past(src_prio_i[1][0]) | $past(src_prio_i[1][1])))
    else $error("or mode priority wrong");

endmodule : pamp_port_regs

// >>> shared/pamp_pkg.sv
// constants shared by the per-port list, mirroring and priority register bank
package pamp_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PORTS   = 3;   // switch ports 1 to 3
  localparam int unsigned ENTRIES     = 16;  // list table entries per port
  localparam int unsigned ENTRY_BYTES = 16;  // access bytes per entry
  localparam int unsigned NUM_SRC     = 5;   // classification sources
  localparam int unsigned ADDR_W      = 16;  // apb byte address width

  // ----------------------------------------------------------------
  // register indices within a port group (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [11:0] ACL_CTRL_IDX   = 12'h612;
  localparam logic [11:0] MIRROR_IDX     = 12'h800;
  localparam logic [11:0] PRIO_IDX       = 12'h801;
  localparam int unsigned PORT_IDX_SHIFT = 12;  // port number sits above the index

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned ACL_WR_DONE_BIT = 6;
  localparam int unsigned ACL_RD_DONE_BIT = 5;
  localparam int unsigned ACL_DIR_BIT     = 4;
  localparam int unsigned ACL_IDX_LSB     = 0;
  localparam int unsigned MIR_RX_BIT      = 6;
  localparam int unsigned MIR_TX_BIT      = 5;
  localparam int unsigned MIR_SNIFFER_BIT = 1;
  localparam int unsigned PRI_HIGHEST_BIT = 7;
  localparam int unsigned PRI_OR_BIT      = 6;
  localparam int unsigned PRI_EN_LSB      = 0;  // bits 4:0 source enables
  // source order in the enable field
  localparam int unsigned SRC_ACL  = 0;
  localparam int unsigned SRC_DSCP = 1;
  localparam int unsigned SRC_UP   = 2;
  localparam int unsigned SRC_VLAN = 3;
  localparam int unsigned SRC_MAC  = 4;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic        DONE_RST        = 1'b1;
  localparam logic [7:0]  CTRL_RST        = 8'h00;
  localparam logic [1:0]  ACL_OP_CYCLES_M1 = 2'h3;  // table op takes 4 cycles

endpackage : pamp_pkg
